// File: bench/colour_matrix_transform_bench.sv
// Purpose: Self-checking bench for the colour matrix stage
// Assumes: AXI4-Lite master tasks, pixel partner model
// Notes: Expected pixels computed by calc, or the input pixel itself in bypass
`timescale 1ns/1ps
`include "colour_map.svh"
module colour_matrix_transform_bench;
    logic aclk = 1'b0; // Bench clock
    logic aresetn = 1'b0; // Reset, low first
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0; // Addresses
    logic [31:0] s_axi_wdata = '0; // Write data
    logic [3:0] s_axi_wstrb = 4'hf; // All lanes
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0; // Write side
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0; // Read side
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid; // Answers
    logic [1:0] s_axi_bresp, s_axi_rresp; // Codes
    logic [31:0] s_axi_rdata; // Read data
    colour_pkg::pixel_t in_pixel, out_pixel; // Pixel lanes
    logic in_valid, in_ready, out_valid, out_ready; // Pixel handshakes
    int failures = 0; // Mismatches
    int num_checks = 0; // Comparisons
    logic [1:0] rsp; // Last response
    logic [31:0] rdv; // Last read value
    logic en = 1'b0; // Expected enable
    colour_pkg::matrix_t cur, um; // Expected and user matrices
    colour_pkg::coef_t c; // One coefficient
    colour_pkg::pixel_t exp_q[$]; // Expected pixels
    // Fixed illuminant tables, nine gains then three offsets
    real d50[12] = '{2.82, -1.08, 0.34, -0.23, 2.61, -1.13, 0.21, -1.27, 5.7, 1.07, 2.88, 0.44};
    real d65[12] = '{3.52, -1.08, 0.15, -0.34, 2.53, -0.83, 0.17, -1.18, 4.35, 2.32, 2.91, 1.24};
    // Clock
    always #4 aclk = ~aclk;
    colour_matrix_transform dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .in_pixel, .in_valid, .in_ready, .out_pixel, .out_valid, .out_ready);
    pixel_partner p (.aclk, .in_ready, .in_pixel, .in_valid, .out_pixel, .out_valid, .out_ready);
    // Word comparison
    task automatic chk32(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            failures++;
            $display("CHECK FAILED %0t word %h want %h", $time, got, want);
        end
    endtask
    // Pixel comparison
    task automatic chk_px(input colour_pkg::pixel_t got, input colour_pkg::pixel_t want);
        num_checks++;
        if (got !== want) begin
            failures++;
            $display("CHECK FAILED %0t pixel %h want %h", $time, got, want);
        end
    endtask
    // Bus write, response into rsp
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        // Ready stays high, so a following call never re-raises it in one step
        rsp = s_axi_bresp;
    endtask
    // Bus read into rdv and rsp
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask
    // Table to Q4.12 gains and integer offsets, rounded to nearest
    function automatic colour_pkg::matrix_t mat(input real t[12]);
        colour_pkg::matrix_t m;
        m = '0;
        for (int i = 0; i < 12; i++) begin
            if (i < 9) m.gain[i] = 16'($rtoi(t[i] * 4096.0 + (t[i] < 0.0 ? -0.5 : 0.5)));
            else m.offset[i - 9] = 16'($rtoi(t[i] + (t[i] < 0.0 ? -0.5 : 0.5)));
        end
        return m;
    endfunction
    // Expected result of the matrix with clamping
    function automatic colour_pkg::pixel_t calc(colour_pkg::pixel_t x);
        int v[3];
        int s;
        logic [11:0] o[3];
        v = '{x.r, x.g, x.b};
        for (int k = 0; k < 3; k++) begin
            s = 0;
            for (int j = 0; j < 3; j++) s += $signed(cur.gain[3 * k + j]) * v[j];
            s = (s >>> 12) + $signed(cur.offset[k]);
            o[k] = s < 0 ? 12'h000 : s > 4095 ? 12'hfff : 12'(s);
        end
        return '{o[0], o[1], o[2]};
    endfunction
    // Send n pixels, optionally fill the FIFO first, then compare
    task automatic run_px(input int n, input bit hold);
        colour_pkg::pixel_t x;
        int k;
        p.stop <= hold;
        for (int i = 0; i < n; i++) begin
            x = 36'({$urandom, $urandom});
            if (i == 0) x = '0;
            if (i == 1) x = '1;
            p.tx.push_back(x);
            exp_q.push_back(en ? calc(x) : x);
        end
        for (k = 0; k < 300 && hold && in_ready !== 1'b0; k++) @(posedge aclk);
        if (hold) chk32(32'(in_ready), 32'h0);
        // Status under stall: queue holds pixels, output waiting
        if (hold) begin
            rd(`OFF_STATUS);
            chk32(rdv, 32'h3);
        end
        p.stop <= 1'b0;
        for (k = 0; k < 5000 && p.rx.size() < n; k++) @(posedge aclk);
        chk32(32'(p.rx.size()), 32'(n));
        while (p.rx.size() != 0 && exp_q.size() != 0) chk_px(p.rx.pop_front(), exp_q.pop_front());
        exp_q.delete();
    endtask
    // Verdict
    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (40000) @(posedge aclk);
        failures++;
        summarize();
    end
    // Test sequence
    initial begin
        void'($urandom(32'h2f05));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFF_CTRL);
        chk32(rdv, `CTRL_RESET);
        rd(`OFF_VALUE);
        chk32(rdv, 32'h1000);
        rd(8'h10);
        chk32({rdv[29:0], rsp}, 32'(`RESP_SLVERR));
        rd(`OFF_STATUS);
        chk32({rdv[29:0], rsp}, 32'(`RESP_OKAY));
        wr(`OFF_STATUS, 32'hffff_ffff);
        chk32(32'(rsp), 32'(`RESP_SLVERR));
        $display("test reset done");
        for (int s = 0; s < 5; s++) begin
            wr(`OFF_CTRL, 32'(s << 1 | 1));
            rd(`OFF_CTRL);
            chk32(rdv, 32'(s << 1 | 1));
        end
        wr(`OFF_CTRL, 32'h0b);
        chk32(32'(rsp), 32'(`RESP_OKAY));
        rd(`OFF_CTRL);
        chk32(rdv, 32'h09);
        // Identity for the untuned presets, later overwritten by user values
        um = '0;
        um.gain[0] = `GAIN_ONE;
        um.gain[4] = `GAIN_ONE;
        um.gain[8] = `GAIN_ONE;
        en = 1'b1;
        for (int s = 0; s < 4; s++) begin
            cur = s == 0 ? mat(d50) : s == 1 ? mat(d65) : um;
            wr(`OFF_CTRL, 32'(s << 1 | 1));
            run_px(6, 1'b0);
        end
        $display("test presets done");
        for (int i = 0; i < 12; i++) begin
            c = i < 9 ? 16'($urandom_range(0, 16'h3000) - 16'h1000) : 16'($urandom_range(0, 200) - 100);
            if (i < 9) um.gain[i] = c;
            else um.offset[i - 9] = c;
            wr(`OFF_VSEL, 32'(i));
            wr(`OFF_VALUE, 32'(c));
        end
        for (int i = 0; i < 12; i++) begin
            c = i < 9 ? um.gain[i] : um.offset[i - 9];
            wr(`OFF_VSEL, 32'(i));
            rd(`OFF_VALUE);
            chk32(rdv, 32'(c));
        end
        wr(`OFF_CTRL, 32'h09);
        cur = um;
        p.slow <= 1'b1;
        run_px(24, 1'b0);
        $display("test user matrix done");
        // Only byte lane one written, low byte keeps its old value
        um.gain[4] = {8'hf0, um.gain[4][7:0]};
        wr(`OFF_VSEL, 32'h4);
        s_axi_wstrb <= 4'h2;
        wr(`OFF_VALUE, 32'h0000_f000);
        s_axi_wstrb <= 4'hf;
        cur = um;
        run_px(6, 1'b0);
        $display("test live update done");
        wr(`OFF_CTRL, 32'h08);
        en = 1'b0;
        run_px(6, 1'b0);
        run_px(48, 1'b1);
        $display("test bypass and fill done");
        summarize();
    end
endmodule

// File: bench/colour_matrix_transform_monitor.sv
// Purpose: Port checker for the colour matrix stage
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to the design's top module
`timescale 1ns/1ps
module colour_matrix_transform_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic in_ready,
    input wire colour_pkg::pixel_t out_pixel,
    input wire logic out_valid,
    input wire logic out_ready
);
    // Single domain, reset masks every check
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    a_pixel_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_pixel))
        else $error("pixel changed under stall");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_reset_idle: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !out_valid && in_ready)
        else $error("outputs busy after reset");
endmodule
bind colour_matrix_transform colour_matrix_transform_monitor mon (.aclk, .aresetn, .s_axi_awready,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .in_ready, .out_pixel, .out_valid, .out_ready);

// File: bench/pixel_partner.sv
// Purpose: Upstream pixel source and downstream sink
// Assumes: Bench fills tx and reads rx
// Notes: slow adds gaps and stalls, stop holds the sink
`timescale 1ns/1ps
module pixel_partner (
    input wire logic aclk,
    input wire logic in_ready,
    output colour_pkg::pixel_t in_pixel,
    output logic in_valid,
    input wire colour_pkg::pixel_t out_pixel,
    input wire logic out_valid,
    output logic out_ready
);
    colour_pkg::pixel_t tx[$]; // Pixels to send
    colour_pkg::pixel_t rx[$]; // Pixels received
    logic slow = 1'b0; // Random gaps and stalls
    logic stop = 1'b0; // Sink held off
    initial begin
        in_pixel = '0;
        in_valid = 1'b0;
        out_ready = 1'b0;
    end
    // Source holds a pixel until taken; idle lanes toggle
    always @(posedge aclk) begin
        if (out_valid && out_ready)
            rx.push_back(out_pixel);
        out_ready <= !stop && (!slow || $urandom_range(0, 1) == 0);
        if (in_valid && in_ready)
            void'(tx.pop_front());
        if (!(in_valid && !in_ready)) begin
            // Offer next pixel or go idle
            if (tx.size() != 0 && (!slow || $urandom_range(0, 2) != 0)) begin
                in_valid <= 1'b1;
                in_pixel <= tx[0];
            end else begin
                in_valid <= 1'b0;
                in_pixel <= ~in_pixel;
            end
        end
    end
endmodule

// File: common/colour_map.svh
// Purpose: Register offsets, fields, reset values and sizes of the colour matrix stage
// Assumes: AXI4-Lite word registers, byte addresses below
// Notes: Gains are signed Q4.12, offsets signed integers
`ifndef COLOUR_MAP_SVH
`define COLOUR_MAP_SVH
// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_VSEL 8'h08
`define OFF_VALUE 8'h0c
// Control fields
`define CTRL_EN_BIT 0
`define CTRL_SEL_LSB 1
`define CTRL_RESET 32'h0000_0000
// Selector codes
`define SEL_D50 3'h0
`define SEL_D65 3'h1
`define SEL_TL84 3'h2
`define SEL_A 3'h3
`define SEL_USER 3'h4
// Value selector: 0..8 gains (row*3+col), 9..11 offsets
`define VSEL_GAINS 4'h9
`define VSEL_LAST 4'hb
// Sizes
`define PIX_W 12
`define COEF_W 16
`define FRAC_W 12
`define PIX_MAX 12'hfff
`define GAIN_ONE 16'h1000
`define FIFO_DEPTH 32
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: common/colour_pkg.sv
// Purpose: Types shared by the colour matrix stage
// Assumes: Widths from colour_map.svh
// Notes: Types only
`include "colour_map.svh"
package colour_pkg;
    // One RGB pixel
    typedef struct packed {
        logic [`PIX_W-1:0] r;
        logic [`PIX_W-1:0] g;
        logic [`PIX_W-1:0] b;
    } pixel_t;
    // One coefficient
    typedef logic signed [`COEF_W-1:0] coef_t;
    // Full coefficient set
    typedef struct packed {
        coef_t [8:0] gain;
        coef_t [2:0] offset;
    } matrix_t;
endpackage

// File: design/colour_matrix_transform.sv
// Purpose: Per-pixel 3x3 colour matrix with offsets
// Assumes: 125 MHz aclk, AXI4-Lite registers
// Notes: One result per cycle, output held under stall
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "colour_map.svh"
module colour_matrix_transform (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Upstream pixels
    input wire colour_pkg::pixel_t in_pixel,
    input wire logic in_valid,
    output logic in_ready,
    // Downstream pixels
    output colour_pkg::pixel_t out_pixel,
    output logic out_valid,
    input wire logic out_ready
);
    // All registered state
    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic enable;
        logic [2:0] sel;
        logic [3:0] vsel;
        colour_pkg::matrix_t user;
        logic ovalid;
        colour_pkg::pixel_t opix;
    } state_t;
    state_t st, next_st;

    // FIFO drain side
    colour_pkg::pixel_t q_pixel;
    logic q_valid;
    logic q_ready;
    // Coefficients in use
    colour_pkg::matrix_t active;

    // Input FIFO, back-pressure to upstream
    pixel_fifo #(
        .WIDTH($bits(colour_pkg::pixel_t)),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_data(in_pixel),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .out_data(q_pixel),
        .out_valid(q_valid),
        .out_ready(q_ready)
    );

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Fixed illuminant tables, Q4.12
    function automatic colour_pkg::matrix_t preset(
        input logic [2:0] sel
    );
        colour_pkg::matrix_t m;
        m.gain = '{default: 16'h0000};
        m.offset = '{default: 16'h0000};
        case (sel)
            `SEL_D50: begin
                m.gain[0] = 16'h2d1f;
                m.gain[1] = 16'heeb8;
                m.gain[2] = 16'h0571;
                m.gain[3] = 16'hfc52;
                m.gain[4] = 16'h29c3;
                m.gain[5] = 16'hedec;
                m.gain[6] = 16'h035c;
                m.gain[7] = 16'hebae;
                m.gain[8] = 16'h5b33;
                m.offset[0] = 16'h0001;
                m.offset[1] = 16'h0003;
                m.offset[2] = 16'h0000;
            end
            `SEL_D65: begin
                m.gain[0] = 16'h3852;
                m.gain[1] = 16'heeb8;
                m.gain[2] = 16'h0266;
                m.gain[3] = 16'hfa8f;
                m.gain[4] = 16'h287b;
                m.gain[5] = 16'hf2b8;
                m.gain[6] = 16'h02b8;
                m.gain[7] = 16'hed1f;
                m.gain[8] = 16'h459a;
                m.offset[0] = 16'h0002;
                m.offset[1] = 16'h0003;
                m.offset[2] = 16'h0001;
            end
            default: begin
                // TL84, A: unity until tuned values exist
                m.gain[0] = `GAIN_ONE;
                m.gain[4] = `GAIN_ONE;
                m.gain[8] = `GAIN_ONE;
            end
        endcase
        return m;
    endfunction

    // One output colour: row dot pixel plus offset
    function automatic logic [`PIX_W-1:0] colour_out(
        input colour_pkg::coef_t g0,
        input colour_pkg::coef_t g1,
        input colour_pkg::coef_t g2,
        input colour_pkg::coef_t off,
        input colour_pkg::pixel_t p
    );
        logic signed [30:0] acc;
        logic signed [30:0] val;
        acc = 31'(g0 * $signed({1'b0, p.r}))
            + 31'(g1 * $signed({1'b0, p.g}))
            + 31'(g2 * $signed({1'b0, p.b}));
        val = (acc >>> `FRAC_W) + 31'(off);
        if (val < 0) begin
            return '0;
        end else if (val > 31'(`PIX_MAX)) begin
            return `PIX_MAX;
        end
        return val[`PIX_W-1:0];
    endfunction

    // Register decode for reads
    function automatic logic [31:0] read_reg(
        input state_t s,
        input logic [7:0] addr,
        input logic fifo_has
    );
        logic [31:0] v;
        v = '0;
        case (addr)
            `OFF_CTRL: begin
                v[`CTRL_EN_BIT] = s.enable;
                v[`CTRL_SEL_LSB +: 3] = s.sel;
            end
            `OFF_STATUS: begin
                v[0] = fifo_has;
                v[1] = s.ovalid;
            end
            `OFF_VSEL: v[3:0] = s.vsel;
            `OFF_VALUE: begin
                if (s.vsel < `VSEL_GAINS) begin
                    v = 32'($signed(s.user.gain[s.vsel]));
                end else begin
                    v = 32'($signed(s.user.offset[s.vsel - `VSEL_GAINS]));
                end
            end
            default: v = '0;
        endcase
        return v;
    endfunction

    // Mapped address check
    function automatic logic mapped(input logic [7:0] a);
        return a == `OFF_CTRL || a == `OFF_STATUS
            || a == `OFF_VSEL || a == `OFF_VALUE;
    endfunction

    // Preset or user coefficients, used live
    always_comb begin
        if (st.sel == `SEL_USER) begin
            active = st.user;
        end else begin
            active = preset(st.sel);
        end
    end

    // Bus handshakes
    assign s_axi_awready = !st.aw_held && !st.bvalid;
    assign s_axi_wready = !st.w_held && !st.bvalid;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = st.rdata;
    // Stream side
    assign q_ready = !st.ovalid || out_ready;
    assign out_valid = st.ovalid;
    assign out_pixel = st.opix;

    // Next-state logic
    always_comb begin
        logic [31:0] wv;
        logic [3:0] idx;
        wv = '0;
        idx = '0;
        next_st = st;
        // Write address capture
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        // Write data capture
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        // Write performs once both halves held
        if (st.aw_held && st.w_held) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = mapped(st.aw_addr) && st.aw_addr != `OFF_STATUS
                ? `RESP_OKAY : `RESP_SLVERR;
            case (st.aw_addr)
                `OFF_CTRL: begin
                    wv = merge({28'h0, st.sel, st.enable}, st.w_data, st.w_strb);
                    next_st.enable = wv[`CTRL_EN_BIT];
                    if (wv[`CTRL_SEL_LSB +: 3] <= `SEL_USER) begin
                        next_st.sel = wv[`CTRL_SEL_LSB +: 3];
                    end
                end
                `OFF_VSEL: begin
                    wv = merge({28'h0, st.vsel}, st.w_data, st.w_strb);
                    if (wv[3:0] <= `VSEL_LAST) begin
                        next_st.vsel = wv[3:0];
                    end
                end
                `OFF_VALUE: begin
                    // Presets are never written here
                    if (st.vsel < `VSEL_GAINS) begin
                        wv = merge({16'h0, st.user.gain[st.vsel]}, st.w_data, st.w_strb);
                        next_st.user.gain[st.vsel] = wv[15:0];
                    end else begin
                        idx = st.vsel - `VSEL_GAINS;
                        wv = merge({16'h0, st.user.offset[idx[1:0]]}, st.w_data, st.w_strb);
                        next_st.user.offset[idx[1:0]] = wv[15:0];
                    end
                end
                default: begin
                    // Status and unmapped ignore writes
                end
            endcase
        end
        // Write response taken
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        // Read
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = read_reg(st, s_axi_araddr, q_valid);
            next_st.rresp = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        // Pixel stage
        if (q_ready) begin
            next_st.ovalid = q_valid;
            if (q_valid) begin
                if (st.enable) begin
                    next_st.opix.r = colour_out(active.gain[0], active.gain[1],
                        active.gain[2], active.offset[0], q_pixel);
                    next_st.opix.g = colour_out(active.gain[3], active.gain[4],
                        active.gain[5], active.offset[1], q_pixel);
                    next_st.opix.b = colour_out(active.gain[6], active.gain[7],
                        active.gain[8], active.offset[2], q_pixel);
                end else begin
                    next_st.opix = q_pixel;
                end
            end
        end
    end

    // State register, user matrix resets to identity
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.user.gain[0] <= `GAIN_ONE;
            st.user.gain[4] <= `GAIN_ONE;
            st.user.gain[8] <= `GAIN_ONE;
        end else begin
            st <= next_st;
        end
    end
endmodule

// File: design/pixel_fifo.sv
// Purpose: Pixel FIFO with valid/ready on both sides
// Assumes: One clock, synchronous active-low reset
// Notes: Depth a power of two
`timescale 1ns/1ps
module pixel_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    // Pointers and fill count
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } fifo_state_t;
    fifo_state_t st, next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    // Honest full and empty
    assign in_ready = st.count != (AW+1)'(DEPTH);
    assign out_valid = st.count != '0;
    assign out_data = mem[st.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Registers and storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
        if (push) begin
            mem[st.wr] <= in_data;
        end
    end
endmodule
